// ===== verilog/system_options_and_device_id.sv
/*
 system options register bank: write-once options, watchdog clock select and
 read-only identification. assumes an apb master on pclk and a separate
 power-on reset input alongside the system reset.
*/
// Contract
// - only the first primary options write after reset is taken; later ones ignored
// - primary options read always returns current contents
// - bit 7 enables the watchdog, forcing reset on timeout
// - bit 6 picks long watchdog timeout, else short
// - bit 5 clear makes a stop instruction an illegal-opcode reset
// - bit 1 selects debug pin function, defaulting to debug on every reset
// - bit 0 selects reset pin function, else input-only port use
// - internal pullup on reset pin while reset function selected
// - reset pin select clears only on power-on reset
// - bit 4 stores and reads back with no effect
// - write-once watchdog clock select: 0 internal 32 kHz, 1 bus clock
// - high ident upper nibble is fixed revision; ident registers read-only
// - high ident low nibble plus low ident form fixed 12-bit part number
`timescale 1ns/100ps

module system_options_and_device_id #(
	parameter logic [3:0]  REVISION    = sysopt_pkg::DEF_REVISION,
	parameter logic [11:0] PART_NUMBER = sysopt_pkg::DEF_PART_NUMBER
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// power-on reset, active low, asserted together with presetn
	input  wire logic        por_n,
	// controls to the rest of the chip
	output logic             watchdog_enable,
	output logic             watchdog_long_timeout,
	output logic             watchdog_clock_select,
	output logic             stop_mode_allow,
	input  wire logic        stop_attempt,
	output logic             illegal_stop_reset,
	output logic             debug_pin_function_select,
	output logic             reset_pin_function_select,
	output logic             reset_pin_pullup_en
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [7:1] opt_hi_ff,     nxt_opt_hi;
	logic       opt_locked_ff, nxt_opt_locked;
	logic       wdclk_ff,      nxt_wdclk;
	logic       wdclk_lock_ff, nxt_wdclk_lock;
	logic [7:0] rdata_ff,      nxt_rdata;
	logic       slverr_ff,     nxt_slverr;
	logic       rst_pin_ff,    nxt_rst_pin;

	logic access;
	logic wr;
	logic hit;
	logic [7:0] primary;

	assign access = psel & penable;
	assign wr     = access & pwrite;
	assign hit    = (paddr == sysopt_pkg::OFS_OPT_PRIMARY)   |
	                (paddr == sysopt_pkg::OFS_OPT_SECONDARY) |
	                (paddr == sysopt_pkg::OFS_IDENT_HIGH)    |
	                (paddr == sysopt_pkg::OFS_IDENT_LOW);

	// bits 3:2 forced zero on read
	assign primary = {opt_hi_ff[7:4], 2'b00, opt_hi_ff[1], rst_pin_ff} &
	                 sysopt_pkg::PRIMARY_WMASK;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_opt_hi     = opt_hi_ff;
		nxt_opt_locked = opt_locked_ff;
		nxt_rst_pin    = rst_pin_ff;
		nxt_wdclk      = wdclk_ff;
		nxt_wdclk_lock = wdclk_lock_ff;
		nxt_rdata      = 8'h00;
		nxt_slverr     = 1'b0;
		if (wr && paddr == sysopt_pkg::OFS_OPT_PRIMARY && !opt_locked_ff) begin
			// first write wins, the lock itself is what software relies on
			nxt_opt_hi     = {pwdata[7:4], 2'b00, pwdata[1]};
			nxt_rst_pin    = pwdata[sysopt_pkg::BIT_RESET_PIN];
			nxt_opt_locked = 1'b1;
		end
		if (wr && paddr == sysopt_pkg::OFS_OPT_SECONDARY && !wdclk_lock_ff) begin
			nxt_wdclk      = pwdata[sysopt_pkg::BIT_WD_CLK_SEL];
			nxt_wdclk_lock = 1'b1;
		end
		if (psel && !penable) begin
			nxt_slverr = ~hit;
			unique case (paddr)
				sysopt_pkg::OFS_OPT_PRIMARY:   nxt_rdata = primary;
				sysopt_pkg::OFS_OPT_SECONDARY: nxt_rdata = {7'h00, wdclk_ff};
				sysopt_pkg::OFS_IDENT_HIGH:    nxt_rdata = {REVISION, PART_NUMBER[11:8]};
				sysopt_pkg::OFS_IDENT_LOW:     nxt_rdata = PART_NUMBER[7:0];
				default:                       nxt_rdata = 8'h00;
			endcase
		end else if (access) begin
			nxt_rdata  = rdata_ff;
			nxt_slverr = slverr_ff;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// debug pin select defaults to debug on every reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opt_hi_ff     <= sysopt_pkg::PRIMARY_RESET_HI;
			opt_locked_ff <= 1'b0;
			wdclk_ff      <= sysopt_pkg::WD_CLK_SEL_RESET;
			wdclk_lock_ff <= 1'b0;
			rdata_ff      <= 8'h00;
			slverr_ff     <= 1'b0;
		end else begin
			opt_hi_ff     <= nxt_opt_hi;
			opt_locked_ff <= nxt_opt_locked;
			wdclk_ff      <= nxt_wdclk;
			wdclk_lock_ff <= nxt_wdclk_lock;
			rdata_ff      <= nxt_rdata;
			slverr_ff     <= nxt_slverr;
		end
	end

	// reset pin select survives ordinary resets, cleared only by power-on
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			rst_pin_ff <= sysopt_pkg::RESET_PIN_POR;
		end else begin
			rst_pin_ff <= nxt_rst_pin;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// read data is registered in setup, so every access takes one wait-free cycle
	assign prdata  = {24'h00_0000, rdata_ff};
	assign pready  = 1'b1;
	assign pslverr = access & slverr_ff;

	assign watchdog_enable           = opt_hi_ff[sysopt_pkg::BIT_WD_ENABLE];
	assign watchdog_long_timeout     = opt_hi_ff[sysopt_pkg::BIT_WD_LONG];
	assign watchdog_clock_select     = wdclk_ff;
	assign stop_mode_allow           = opt_hi_ff[sysopt_pkg::BIT_STOP_ALLOW];
	assign illegal_stop_reset        = stop_attempt & ~opt_hi_ff[sysopt_pkg::BIT_STOP_ALLOW];
	assign debug_pin_function_select = opt_hi_ff[sysopt_pkg::BIT_DEBUG_PIN];
	assign reset_pin_function_select = rst_pin_ff;
	assign reset_pin_pullup_en       = rst_pin_ff;
endmodule

// ===== verilog/sysopt_pkg.sv
/*
 package for the system options and device identification register bank.
 assumes an apb slave with 32-bit data, one register per aligned word.
*/
package sysopt_pkg;
	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_OPT_PRIMARY   = 8'h00;
	localparam logic [7:0] OFS_OPT_SECONDARY = 8'h04;
	localparam logic [7:0] OFS_IDENT_HIGH    = 8'h08;
	localparam logic [7:0] OFS_IDENT_LOW     = 8'h0C;
	localparam logic [7:0] OFS_RESET_CAUSE   = 8'h10;

	// ------------------------------------------------------------
	// primary and secondary options field positions
	// ------------------------------------------------------------
	localparam int BIT_WD_ENABLE   = 7;
	localparam int BIT_WD_LONG     = 6;
	localparam int BIT_STOP_ALLOW  = 5;
	localparam int BIT_SPARE       = 4;
	localparam int BIT_DEBUG_PIN   = 1;
	localparam int BIT_RESET_PIN   = 0;
	localparam int BIT_WD_CLK_SEL  = 0;

	// writable bits of the primary options register; bits 3:2 read zero
	localparam logic [7:0] PRIMARY_WMASK = 8'hF3;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	// bits 7:1 = 1,1,0,1,0,0,1: stop mode disallowed after reset
	localparam logic [6:0] PRIMARY_RESET_HI   = 7'h69;
	localparam logic       RESET_PIN_POR      = 1'b0;
	localparam logic       WD_CLK_SEL_RESET   = 1'b0;

	// ------------------------------------------------------------
	// identification, values arbitrary
	// ------------------------------------------------------------
	localparam logic [3:0]  DEF_REVISION    = 4'h0;
	localparam logic [11:0] DEF_PART_NUMBER = 12'h0A5;
endpackage

// ===== test/sysopt_properties.sv
/*
 checker for the options and ident bank.
 assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module sysopt_check #(
	parameter logic [3:0]  REVISION    = 4'h0,
	parameter logic [11:0] PART_NUMBER = 12'h000
) (
	input wire logic        pclk, presetn, psel, penable, pwrite, stop_attempt,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic        watchdog_enable, watchdog_long_timeout, stop_mode_allow,
	input wire logic        illegal_stop_reset, debug_pin_function_select,
	input wire logic        reset_pin_function_select, reset_pin_pullup_en
);
	// ----------------------------------------
	// lock tracking, cleared by system reset
	// ----------------------------------------
	logic lock_ff, nxt_lock, wr0, acc;
	assign wr0 = psel & penable & pwrite & (paddr == 8'h00);
	assign acc = psel & penable & !pwrite;
	always_comb nxt_lock = lock_ff | wr0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) lock_ff <= 1'b0;
		else lock_ff <= nxt_lock;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_pullup_tracks:
	assert property (reset_pin_pullup_en == reset_pin_function_select) else $error("pullup off");
	chk_stop_illegal:
	assert property (illegal_stop_reset == (stop_attempt & !stop_mode_allow)) else $error("stop");
	chk_first_write:
	assert property (wr0 && !lock_ff |=> watchdog_enable == $past(pwdata[7])
		&& watchdog_long_timeout == $past(pwdata[6])) else $error("first write lost");
	chk_lock_holds:
	assert property (wr0 && lock_ff |=> $stable(watchdog_enable) && $stable(stop_mode_allow)
		&& $stable(debug_pin_function_select)) else $error("second write taken");
	chk_read_back:
	assert property (acc && paddr == 8'h00 |-> prdata[7:0] == {watchdog_enable,
		watchdog_long_timeout, stop_mode_allow, prdata[4], 2'b00, debug_pin_function_select,
		reset_pin_function_select}) else $error("primary read wrong");
	chk_ident_high:
	assert property (acc && paddr == 8'h08 |-> prdata[7:0] == {REVISION, PART_NUMBER[11:8]})
		else $error("ident high");
	chk_ident_low:
	assert property (acc && paddr == 8'h0C |-> prdata[7:0] == PART_NUMBER[7:0]) else $error("id");
	chk_reset_values:
	assert property ($rose(presetn) |-> debug_pin_function_select && watchdog_enable
		&& !stop_mode_allow) else $error("reset values");
endmodule
bind system_options_and_device_id sysopt_check #(.REVISION(REVISION),
	.PART_NUMBER(PART_NUMBER)) chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
	.stop_attempt, .paddr, .pwdata, .prdata, .watchdog_enable, .watchdog_long_timeout,
	.stop_mode_allow, .illegal_stop_reset, .debug_pin_function_select,
	.reset_pin_function_select, .reset_pin_pullup_en);

// ===== test/system_options_and_device_id_bench.sv
/*
 bench for the options and ident bank over apb.
 assumes pready answers; every wait is bounded.
*/
`timescale 1ns/100ps
module system_options_and_device_id_bench;
	logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, stop_attempt = 0;
	logic [7:0] paddr = 0, d, r;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, watchdog_enable, watchdog_long_timeout, watchdog_clock_select;
	logic stop_mode_allow, illegal_stop_reset, debug_pin_function_select;
	logic reset_pin_function_select, reset_pin_pullup_en;
	logic [7:0] q[$];
	int error_cnt = 0, samples_checked = 0;
	localparam logic [11:0] PN = sysopt_pkg::DEF_PART_NUMBER;
	always #50 pclk = ~pclk;
	system_options_and_device_id dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .por_n, .watchdog_enable, .watchdog_long_timeout,
		.watchdog_clock_select, .stop_mode_allow, .stop_attempt, .illegal_stop_reset,
		.debug_pin_function_select, .reset_pin_function_select, .reset_pin_pullup_en);
	task final_report;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task ck(input logic v, input logic e);
		samples_checked++;
		if (v !== e) begin
			error_cnt++;
			$display("mismatch at %0t: output level", $time);
		end
	endtask
	task rst(input logic p);
		presetn <= 0;
		por_n <= !p;
		repeat (10) @(posedge pclk);
		presetn <= 1;
		por_n <= 1;
		@(posedge pclk);
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] v);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, v};
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			final_report();
		end
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		xfer(0, a, 8'h00);
	endtask
	// read results are compared in order of issue
	always @(posedge pclk) if (psel && penable && pready) begin
		samples_checked++;
		if (pslverr !== (paddr > 8'h0C)) begin
			error_cnt++;
			$display("mismatch at %0t: slave error %b", $time, pslverr);
		end
	end
	always @(posedge pclk) if (psel && penable && !pwrite && pready) begin
		samples_checked++;
		if (q.size() == 0 || prdata[7:0] !== q[0]) begin
			error_cnt++;
			$display("mismatch at %0t: read %h", $time, prdata[7:0]);
		end
		if (q.size() != 0) void'(q.pop_front());
	end
	initial begin
		void'($urandom(32'h42fffa33));
		rst(1);
		r = 0;
		for (int i = 0; i < 2; i++) begin
			rd(8'h00, 8'hD2 | r);
			rd(8'h04, 8'h00);
			d = 8'($urandom);
			d[0] = 1;
			xfer(1, 8'h08, d);
			rd(8'h08, {sysopt_pkg::DEF_REVISION, PN[11:8]});
			rd(8'h0C, PN[7:0]);
			xfer(1, 8'h00, d);
			xfer(1, 8'h00, ~d);
			rd(8'h00, d & 8'hF3);
			ck(watchdog_enable, d[7]);
			ck(watchdog_long_timeout, d[6]);
			ck(debug_pin_function_select, d[1]);
			ck(reset_pin_pullup_en, d[0]);
			ck(reset_pin_function_select, d[0]);
			ck(stop_mode_allow, d[5]);
			stop_attempt <= 1;
			@(posedge pclk);
			ck(illegal_stop_reset, !d[5]);
			stop_attempt <= 0;
			xfer(1, 8'h04, 8'h01);
			xfer(1, 8'h04, 8'h00);
			rd(8'h04, 8'h01);
			ck(watchdog_clock_select, 1'b1);
			xfer(1, 8'h14, d);
			rd(8'h14, 8'h00);
			r = d & 8'h01;
			rst(0);
		end
		rst(1);
		rd(8'h00, 8'hD2);
		final_report();
	end
endmodule
